// ===== logic/reset_and_stop_recovery_ctrl.sv
`timescale 1ns/10ps
// Contract
// RL1 - Power-on or brown-out starts system reset
// RL2 - Watchdog resets only if option selects reset
// RL3 - Reset pin acts only when alternate enabled
// RL4 - Debug control bit zero set forces reset
// RL5 - Watchdog in STOP starts stop recovery
// RL6 - Enabled GPIO edge in STOP starts recovery
// RL7 - System reset holds CPU 66 oscillator cycles
// RL8 - Recovery resets CPU, watchdog, oscillator regs only
// RL9 - Crystal enabled lengthens system reset duration; the count loaded by RST_I is SYS_LEN (66) whatever the crystal option
// RL10 - Oscillator-tick counter restarts while sources asserted
module reset_and_stop_recovery_ctrl #(
  parameter int unsigned RESET_CYC = rst_ctrl_pkg::OSC_CYCLES_RESET,
  parameter int unsigned OSC_START_CYC = rst_ctrl_pkg::OSC_STARTUP_CYC,
  parameter int unsigned XTAL_START_CYC = rst_ctrl_pkg::XTAL_STARTUP_CYC,
  parameter int unsigned GPIO_W = rst_ctrl_pkg::GPIO_W
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic OSC_TICK_I,
  input wire logic POWER_ON_I,
  input wire logic SUPPLY_BROWNOUT_RESET_I,
  input wire logic WATCHDOG_TIMEOUT_I,
  input wire logic WATCHDOG_RESET_SELECT_OPTION_I,
  input wire logic EXT_RESET_PIN_N_I,
  input wire logic EXT_RESET_AF_EN_I,
  input wire logic DEBUG_UNIT_CONTROL_REG_BIT0_I,
  input wire logic STOP_MODE_I,
  input wire logic [GPIO_W-1:0] GPIO_IN_I,
  input wire logic [GPIO_W-1:0] STOP_RECOVERY_SRC_EN_I,
  input wire logic XTAL_ENABLE_OPTION_I,
  output logic CPU_RESET_O,
  output logic CTRL_REGS_RESET_O,
  output logic WDT_OSC_REGS_RESET_O,
  output logic [1:0] RESET_KIND_O
);

  // ----------------------------------------
  // Load lengths
  // ----------------------------------------
  localparam logic [rst_ctrl_pkg::CNT_W-1:0] SYS_LEN =
    rst_ctrl_pkg::CNT_W'(RESET_CYC);
  localparam logic [rst_ctrl_pkg::CNT_W-1:0] SYS_XTAL_LEN =
    rst_ctrl_pkg::CNT_W'(RESET_CYC + XTAL_START_CYC);
  localparam logic [rst_ctrl_pkg::CNT_W-1:0] SMR_LEN =
    rst_ctrl_pkg::CNT_W'(RESET_CYC + OSC_START_CYC);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rst_ctrl_pkg::sys_src_type src;
  logic sys_req;
  logic smr_req;
  logic smr_allowed;
  logic load;
  logic [GPIO_W-1:0] gpio_prev_r;
  logic [GPIO_W-1:0] gpio_prev_nxt;
  logic [GPIO_W-1:0] gpio_edge;
  logic [rst_ctrl_pkg::CNT_W-1:0] cnt_r;
  logic [rst_ctrl_pkg::CNT_W-1:0] cnt_nxt;
  rst_ctrl_pkg::reset_kind_type kind_r;
  rst_ctrl_pkg::reset_kind_type kind_nxt;
  logic cpu_rst_r;
  logic cpu_rst_nxt;
  logic ctrl_rst_r;
  logic ctrl_rst_nxt;
  logic wo_rst_r;
  logic wo_rst_nxt;

  // ----------------------------------------
  // Latency selection
  // ----------------------------------------
  // One place for the load value used on the load path; the RST_I path loads SYS_LEN directly
  function automatic logic [rst_ctrl_pkg::CNT_W-1:0] load_len(
    input rst_ctrl_pkg::reset_kind_type kind,
    input logic xtal
  );
    logic [rst_ctrl_pkg::CNT_W-1:0] len;
    len = rst_ctrl_pkg::CNT_ZERO;
    case (kind)
      rst_ctrl_pkg::KIND_SYSTEM: begin
        len = xtal ? SYS_XTAL_LEN : SYS_LEN; // RL7 RL9
      end
      rst_ctrl_pkg::KIND_STOP_RECOVERY: begin
        len = SMR_LEN; // RL8
      end
      default: begin
        len = rst_ctrl_pkg::CNT_ZERO;
      end
    endcase
    return len;
  endfunction

  // ----------------------------------------
  // Recovery pin samplers
  // ----------------------------------------
  // Reset loads the live pin level, so no false edge follows reset
  for (genvar i = 0; i < GPIO_W; i++) begin : g_pin
    always_comb begin
      gpio_prev_nxt[i] = GPIO_IN_I[i];
      gpio_edge[i] = (GPIO_IN_I[i] ^ gpio_prev_r[i]) & STOP_RECOVERY_SRC_EN_I[i]; // RL6
    end

    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        gpio_prev_r[i] <= GPIO_IN_I[i];
      end else begin
        gpio_prev_r[i] <= gpio_prev_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // Source combining
  // ----------------------------------------
  always_comb begin
    src.power_on = POWER_ON_I; // RL1
    src.brownout = SUPPLY_BROWNOUT_RESET_I; // RL1
    src.watchdog = WATCHDOG_TIMEOUT_I & ~STOP_MODE_I & WATCHDOG_RESET_SELECT_OPTION_I; // RL2
    src.ext_pin = ~EXT_RESET_PIN_N_I & EXT_RESET_AF_EN_I; // RL3
    src.debug = DEBUG_UNIT_CONTROL_REG_BIT0_I; // RL4
    sys_req = |src;
    smr_req = STOP_MODE_I & (WATCHDOG_TIMEOUT_I | (|gpio_edge)); // RL5 RL6
    // A pending system reset wins; once its count is done recovery may start
    smr_allowed = (kind_r != rst_ctrl_pkg::KIND_SYSTEM) ||
      (cnt_r == rst_ctrl_pkg::CNT_ZERO);
    load = sys_req | (smr_req & smr_allowed); // RL10
  end

  // ----------------------------------------
  // Reset kind
  // ----------------------------------------
  always_comb begin
    kind_nxt = kind_r;
    if (sys_req) begin
      kind_nxt = rst_ctrl_pkg::KIND_SYSTEM; // RL1 RL2 RL3 RL4
    end else if (smr_req && smr_allowed) begin
      kind_nxt = rst_ctrl_pkg::KIND_STOP_RECOVERY; // RL5 RL6
    end else if (cnt_r == rst_ctrl_pkg::CNT_ZERO) begin
      kind_nxt = rst_ctrl_pkg::KIND_NONE;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      kind_r <= rst_ctrl_pkg::KIND_SYSTEM;
    end else begin
      kind_r <= kind_nxt;
    end
  end

  // ----------------------------------------
  // Latency counter
  // ----------------------------------------
  // Counting in oscillator ticks keeps the latency fixed even if the system clock moves
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_len(kind_nxt, XTAL_ENABLE_OPTION_I); // RL7 RL8 RL9 RL10
    end else if (cnt_r != rst_ctrl_pkg::CNT_ZERO) begin
      if (OSC_TICK_I) begin
        cnt_nxt = cnt_r - rst_ctrl_pkg::CNT_ONE; // RL10
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      cnt_r <= SYS_LEN;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // Reset outputs
  // ----------------------------------------
  always_comb begin
    cpu_rst_nxt = (cnt_nxt != rst_ctrl_pkg::CNT_ZERO); // RL7 RL8
    case (kind_nxt)
      rst_ctrl_pkg::KIND_SYSTEM: begin
        ctrl_rst_nxt = cpu_rst_nxt; // RL7
        wo_rst_nxt = cpu_rst_nxt;
      end
      rst_ctrl_pkg::KIND_STOP_RECOVERY: begin
        ctrl_rst_nxt = 1'b0; // RL8
        wo_rst_nxt = cpu_rst_nxt; // RL8
      end
      default: begin
        ctrl_rst_nxt = 1'b0;
        wo_rst_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      cpu_rst_r <= 1'b1;
      ctrl_rst_r <= 1'b1;
      wo_rst_r <= 1'b1;
    end else begin
      cpu_rst_r <= cpu_rst_nxt;
      ctrl_rst_r <= ctrl_rst_nxt;
      wo_rst_r <= wo_rst_nxt;
    end
  end

  // ----------------------------------------
  // Port drive
  // ----------------------------------------
  // Each output is a flip-flop; nothing combinational reaches the pins
  assign CPU_RESET_O = cpu_rst_r;
  assign CTRL_REGS_RESET_O = ctrl_rst_r;
  assign WDT_OSC_REGS_RESET_O = wo_rst_r;
  assign RESET_KIND_O = kind_r;

endmodule // reset_and_stop_recovery_ctrl

// ===== include/rst_ctrl_pkg.sv
package rst_ctrl_pkg;

  // ----------------------------------------
  // Latency figures
  // ----------------------------------------
  localparam int unsigned OSC_CYCLES_RESET = 66;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam int unsigned OSC_STARTUP_CYC = 16;
  localparam int unsigned XTAL_STARTUP_CYC = 256;
  localparam int unsigned GPIO_W = 8;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_SYSTEM,
    KIND_STOP_RECOVERY
  } reset_kind_type;

  typedef struct packed {
    logic power_on;
    logic brownout;
    logic watchdog;
    logic ext_pin;
    logic debug;
  } sys_src_type;

endpackage

// ===== sim/osc_tick_model.sv
`timescale 1ns/10ps
module osc_tick_model(input wire logic clk_i, output logic tick_o = 1'b0);
  always @(posedge clk_i) tick_o <= !tick_o;
endmodule // osc_tick_model

// ===== sim/rst_ctrl_monitor.sv
`timescale 1ns/10ps
module rst_ctrl_monitor(input wire logic CLK_SYS_I, RST_I, POWER_ON_I, STOP_MODE_I,
  WATCHDOG_TIMEOUT_I, DEBUG_UNIT_CONTROL_REG_BIT0_I, CPU_RESET_O, CTRL_REGS_RESET_O,
  WDT_OSC_REGS_RESET_O, input wire logic [1:0] RESET_KIND_O);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  por_kind_a: assert property (POWER_ON_I |=> RESET_KIND_O == 2'h1) else $error("kind");
  por_hold_a: assert property ($fell(POWER_ON_I) |-> CPU_RESET_O [*8]) else $error("hold");
  dbg_rst_a: assert property (DEBUG_UNIT_CONTROL_REG_BIT0_I |=> CPU_RESET_O) else $error("d");
  stop_wdt_a: assert property (STOP_MODE_I && WATCHDOG_TIMEOUT_I |=> WDT_OSC_REGS_RESET_O)
    else $error("stop");
  rec_regs_a: assert property (RESET_KIND_O[1] && CPU_RESET_O |-> !CTRL_REGS_RESET_O)
    else $error("rec");
  sys_regs_a: assert property (RESET_KIND_O[0] && CPU_RESET_O |-> CTRL_REGS_RESET_O)
    else $error("sys");
  drop_all_a: assert property ($fell(CPU_RESET_O) |-> !WDT_OSC_REGS_RESET_O) else $error("drop");
  kind_idle_a: assert property ($fell(CPU_RESET_O) |=> RESET_KIND_O == 2'h0) else $error("idle");
endmodule // rst_ctrl_monitor
bind reset_and_stop_recovery_ctrl rst_ctrl_monitor mon(.*);

// ===== sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk = 0, rst = 1, tick, cpu, ctl, wo;
  logic [1:0] kind;
  logic [8:0] v = 0;
  logic [7:0] gp = 0, en = 0;
  int fails = 0, n_checks = 0;
  always #2 clk = ~clk;
  osc_tick_model osc(.clk_i(clk), .tick_o(tick));
  reset_and_stop_recovery_ctrl uut(.CLK_SYS_I(clk), .RST_I(rst), .OSC_TICK_I(tick),
    .POWER_ON_I(v[8]), .SUPPLY_BROWNOUT_RESET_I(v[7]), .WATCHDOG_TIMEOUT_I(v[6]),
    .WATCHDOG_RESET_SELECT_OPTION_I(v[5]), .EXT_RESET_PIN_N_I(!v[4]), .EXT_RESET_AF_EN_I(v[3]),
    .DEBUG_UNIT_CONTROL_REG_BIT0_I(v[2]), .STOP_MODE_I(v[1]), .XTAL_ENABLE_OPTION_I(v[0]),
    .GPIO_IN_I(gp), .STOP_RECOVERY_SRC_EN_I(en), .CPU_RESET_O(cpu), .CTRL_REGS_RESET_O(ctl),
    .WDT_OSC_REGS_RESET_O(wo), .RESET_KIND_O(kind));
  task chk(string s, logic [15:0] e, logic [15:0] g);
    n_checks++;
    fails += int'(g !== e);
    if (g !== e) $display("wrong value %s exp %0h got %0h", s, e, g);
  endtask
  task test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Crystal bit stays up through the count; tick count may be off by up to two ticks
  task go(logic [8:0] s, logic [7:0] g);
    int y, r, t;
    y = s[8] | s[7] | s[6] & s[5] & !s[1] | s[4] & s[3] | s[2];
    r = !y & s[1] & (s[6] | |(g & en));
    t = y ? 66 + 256 * s[0] : 82 * r;
    r = y ? 7 : 9 * r;
    v = s;
    @(posedge clk) #1 gp ^= g;
    repeat (2) @(posedge clk) #1;
    chk("kind", 16'(r), {kind, ctl, wo});
    v = s & 9'h001;
    while (cpu === 1'b1 && t > -9) @(posedge clk) #1 t -= tick;
    chk("ticks", 1, t < 3 && t > -2);
    repeat (2) @(posedge clk) #1;
  endtask
  initial begin
    void'($urandom(35333));
    en = 8'($urandom) | 8'h01;
    repeat (16) @(posedge clk) #1;
    chk("reset", 16'h0007, {kind, ctl, wo});
    rst = 0;
    repeat (150) @(posedge clk) #1;
    repeat (60) go(9'($urandom), 8'($urandom));
    test_done;
  end
  initial begin
    #300000;
    fails++;
    test_done;
  end
endmodule // testbench
